/* sdadc_regs.svh */
// Constants of the sigma-delta converter control: control word layout, reset word, mode codes, timing.
// Assumes a 100 MHz system clock; included by the package and by both ends.
`ifndef SDADC_REGS_SVH
`define SDADC_REGS_SVH
`define CTRL_W 24
`define MODE_MSB 23
`define MODE_LSB 21
`define CHAN_BIT 20
`define FS_MSB 11
`define FS_LSB 0
`define CTRL_RST 24'h000186
`define MODE_NORMAL 3'h0
`define MODE_SELF 3'h1
`define MODE_SYS_ZERO 3'h2
`define MODE_SYS_FULL 3'h3
`define MODE_SYS_OFFSET 3'h4
`define MODE_BACKGROUND 3'h5
`define FS_MIN 12'h013
`define FS_MAX 12'h7CE
`define CLK_HZ 100000000
`define MOD_RATE_HZ 19500
`define SETTLE_PERIODS 3'h4
`define BG_SLOTS 3'h6
`define DIV_W 16
`endif

/* sdadc_pkg.sv */
// Types shared by both ends of the converter control link.
// Assumes sdadc_regs.svh for the widths.
`include "sdadc_regs.svh"
package sdadc_pkg;
  typedef logic [`CTRL_W-1:0] ctrl_t;
  typedef logic [2:0] mode_t;
  typedef enum logic [1:0] {AIN_INPUT, AIN_SHORT, AIN_REF} ain_t;
  typedef enum logic [2:0] {CAL_IDLE, CAL_ZERO, CAL_FULL, BG_RUN} cal_state_t;
  typedef enum logic [2:0] {H_BOOT, H_CAL, H_WAIT, H_USER, H_IDLE} host_state_t;
  typedef struct packed {
    logic [23:0] data;
    logic chan;
    logic settled;
  } result_t;
endpackage

/* adc_link.sv */
// Link between the converter control end and the controlling microcontroller end.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface adc_link;
  import sdadc_pkg::*;
  logic ctrl_wr;
  ctrl_t ctrl_wdata;
  ctrl_t ctrl_rdata;
  logic busy;
  logic settled;
  logic overrun;
  logic res_valid;
  logic res_ready;
  result_t res;
  modport dev (input ctrl_wr, ctrl_wdata, res_ready, output ctrl_rdata, busy, settled, overrun, res_valid, res);
  modport host (output ctrl_wr, ctrl_wdata, res_ready, input ctrl_rdata, busy, settled, overrun, res_valid, res);
endinterface

/* sdadc_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module sdadc_buf2 #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  // Honest full and empty from the entry count
  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointer with wrap
  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= inc(wr_reg);
      end
      if (pop) begin
        rd_reg <= inc(rd_reg);
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sdadc_buf2

/* sdadc_device.sv */
// Converter control end: control word, decimating filter, settling tracking, calibration modes.
// Assumes the modulator bit arrives synchronous to clk_sys and the analog mux follows ain_sel.
// Summary of operation
// - Decimate fixed-rate modulator results to output rate
// - Twelve-bit filter select sets the notch
// - Cutoff spans lowest to highest programmable value
// - Output rate equals notch; settle four periods
// - Controller treats results invalid until settled; background-mode results are always marked settled, even before then
// - Controller waits settling after channel switch
// - Power-up reset loads defined control word
// - Top three bits select operating mode
// - Self calibration: shorted zero, reference span
// - System zero step converts applied zero
// - System full step converts applied full scale
// - Offset mode: input zero, reference span
// - Background mode interleaves calibration, one sixth rate
// - Controller calibrates after power-up and changes
// - Controller recalibrates after channel or notch change
`timescale 1ns/1ps
`include "sdadc_regs.svh"
module sdadc_device #(
  parameter int MOD_DIV = `CLK_HZ / `MOD_RATE_HZ
) (
  input wire logic clk_sys,
  input wire logic rst,
  adc_link.dev link,
  input wire logic mod_bit,
  output sdadc_pkg::ain_t ain_sel,
  output logic chan_sel,
  output logic [23:0] zero_coef,
  output logic [23:0] span_coef
);
  import sdadc_pkg::*;

  ctrl_t ctrl_reg;
  cal_state_t state_reg;
  mode_t kind_reg;
  ain_t ain_reg;
  logic [`DIV_W-1:0] div_reg;
  logic [11:0] dec_reg;
  logic [11:0] acc_reg;
  logic [23:0] raw_reg;
  logic conv_reg;
  logic [2:0] settle_reg;
  logic [2:0] slot_reg;
  logic [23:0] zero_reg;
  logic [23:0] span_reg;
  logic mux_chg_reg;
  logic overrun_reg;
  logic push;
  logic buf_ready;
  logic mod_tick;
  logic restart;
  logic settled;
  logic [11:0] dec_len;
  result_t res_in;

  // Filter select clamped to the programmable notch range
  function automatic logic [11:0] clamp_fs(input ctrl_t c);
    logic [11:0] fs;
    fs = c[`FS_MSB:`FS_LSB];
    if (fs < `FS_MIN) begin
      clamp_fs = `FS_MIN;
    end else if (fs > `FS_MAX) begin
      clamp_fs = `FS_MAX;
    end else begin
      clamp_fs = fs;
    end
  endfunction

  assign dec_len = clamp_fs(ctrl_reg);
  assign mod_tick = (div_reg == `DIV_W'(MOD_DIV - 1));
  assign restart = link.ctrl_wr || mux_chg_reg;
  assign settled = (settle_reg == `SETTLE_PERIODS);

  // Control word: reset default, host write, mode cleared when a one-shot calibration ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RST;
    end else if (link.ctrl_wr) begin
      ctrl_reg <= link.ctrl_wdata;
    end else if (conv_reg && settled && ((state_reg == CAL_FULL) ||
        (state_reg == CAL_ZERO && kind_reg == `MODE_SYS_ZERO))) begin
      ctrl_reg[`MODE_MSB:`MODE_LSB] <= `MODE_NORMAL;
    end
  end

  // Modulator sample tick at the fixed internal rate
  always_ff @(posedge clk_sys) begin
    if (rst || mod_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Decimating filter: sums modulator bits over the programmed count
  always_ff @(posedge clk_sys) begin
    if (rst || restart) begin
      dec_reg <= '0;
      acc_reg <= '0;
      conv_reg <= 1'b0;
    end else begin
      conv_reg <= 1'b0;
      if (mod_tick) begin
        if (dec_reg == dec_len - 1'b1) begin
          dec_reg <= '0;
          acc_reg <= '0;
          raw_reg <= {12'h000, acc_reg + 12'(mod_bit)};
          conv_reg <= 1'b1;
        end else begin
          dec_reg <= dec_reg + 1'b1;
          acc_reg <= acc_reg + 12'(mod_bit);
        end
      end
    end
  end

  // Settling count: four output periods after any word write or calibration-step input change; background slot changes do not restart it
  always_ff @(posedge clk_sys) begin
    if (rst || restart) begin
      settle_reg <= '0;
    end else if (conv_reg && !settled) begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  // Calibration sequencer and mux control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= CAL_IDLE;
      kind_reg <= `MODE_NORMAL;
      ain_reg <= AIN_INPUT;
      zero_reg <= '0;
      span_reg <= '0;
      slot_reg <= '0;
      mux_chg_reg <= 1'b0;
    end else begin
      mux_chg_reg <= 1'b0;
      if (link.ctrl_wr) begin
        kind_reg <= link.ctrl_wdata[`MODE_MSB:`MODE_LSB];
        slot_reg <= '0;
        case (link.ctrl_wdata[`MODE_MSB:`MODE_LSB])
          `MODE_SELF: begin
            state_reg <= CAL_ZERO;
            ain_reg <= AIN_SHORT;
          end
          `MODE_SYS_ZERO, `MODE_SYS_OFFSET: begin
            state_reg <= CAL_ZERO;
            ain_reg <= AIN_INPUT;
          end
          `MODE_SYS_FULL: begin
            state_reg <= CAL_FULL;
            ain_reg <= AIN_INPUT;
          end
          `MODE_BACKGROUND: begin
            state_reg <= BG_RUN;
            ain_reg <= AIN_INPUT;
          end
          default: begin
            state_reg <= CAL_IDLE;
            ain_reg <= AIN_INPUT;
          end
        endcase
      end else begin
        case (state_reg)
          CAL_ZERO: begin
            if (conv_reg && settled) begin
              zero_reg <= raw_reg;
              mux_chg_reg <= 1'b1;
              if (kind_reg == `MODE_SYS_ZERO) begin
                state_reg <= CAL_IDLE;
                ain_reg <= AIN_INPUT;
              end else begin
                state_reg <= CAL_FULL;
                ain_reg <= AIN_REF;
              end
            end
          end
          CAL_FULL: begin
            if (conv_reg && settled) begin
              span_reg <= raw_reg - zero_reg;
              state_reg <= CAL_IDLE;
              ain_reg <= AIN_INPUT;
              mux_chg_reg <= 1'b1;
            end
          end
          BG_RUN: begin
            // Slot 0 normal, slot 1 shorted zero, slot 2 reference, slots 3-5 discarded
            if (conv_reg) begin
              slot_reg <= (slot_reg == `BG_SLOTS - 1'b1) ? 3'h0 : slot_reg + 1'b1;
              if (slot_reg == 3'h1) begin
                zero_reg <= raw_reg;
              end
              if (slot_reg == 3'h2) begin
                span_reg <= raw_reg - zero_reg;
              end
              ain_reg <= (slot_reg == 3'h0) ? AIN_SHORT : (slot_reg == 3'h1) ? AIN_REF : AIN_INPUT;
            end
          end
          default: begin
            state_reg <= CAL_IDLE;
          end
        endcase
      end
    end
  end

  // Result words: normal mode every conversion, background slot 0 only
  assign push = conv_reg && ((state_reg == CAL_IDLE) || (state_reg == BG_RUN && slot_reg == 3'h0));
  assign res_in.data = raw_reg - zero_reg;
  assign res_in.chan = ctrl_reg[`CHAN_BIT];
  assign res_in.settled = settled || (state_reg == BG_RUN);

  // Overrun when the buffer is full; a new event wins over the clearing write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overrun_reg <= 1'b0;
    end else if (push && !buf_ready) begin
      overrun_reg <= 1'b1;
    end else if (link.ctrl_wr) begin
      overrun_reg <= 1'b0;
    end
  end

  sdadc_buf2 #(.WIDTH($bits(result_t)), .DEPTH(2)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(res_in),
    .out_valid(link.res_valid),
    .out_ready(link.res_ready),
    .out_data(link.res)
  );

  // Status and readback to the controller
  assign link.ctrl_rdata = ctrl_reg;
  assign link.busy = (state_reg == CAL_ZERO) || (state_reg == CAL_FULL);
  assign link.settled = settled;
  assign link.overrun = overrun_reg;
  assign ain_sel = ain_reg;
  assign chan_sel = ctrl_reg[`CHAN_BIT];
  assign zero_coef = zero_reg;
  assign span_coef = span_reg;
endmodule // sdadc_device

/* sdadc_host.sv */
// Controller end: writes the control word, calibrates at power-up and after channel or notch changes,
// and passes on only results marked settled, which includes every background-mode result. Assumes the device end on the same clk_sys.
`timescale 1ns/1ps
`include "sdadc_regs.svh"
module sdadc_host (
  input wire logic clk_sys,
  input wire logic rst,
  adc_link.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sdadc_pkg::ctrl_t cmd_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [23:0] out_data,
  output logic out_chan,
  output logic cal_busy
);
  import sdadc_pkg::*;

  host_state_t state_reg;
  ctrl_t pend_reg;
  ctrl_t last_reg;
  logic wr_reg;
  ctrl_t wdata_reg;
  logic valid_reg;
  logic [23:0] data_reg;
  logic chan_reg;

  // Channel or notch differs from the word last written
  function automatic logic needs_cal(input ctrl_t a, input ctrl_t b);
    needs_cal = (a[`CHAN_BIT] != b[`CHAN_BIT]) || (a[`FS_MSB:`FS_LSB] != b[`FS_MSB:`FS_LSB]);
  endfunction

  // New commands only in H_IDLE, after the controller's own write and calibration; link busy is not checked
  assign cmd_ready = (state_reg == H_IDLE);

  // Command sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= H_BOOT;
      pend_reg <= `CTRL_RST;
      last_reg <= `CTRL_RST;
      wr_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      wr_reg <= 1'b0;
      case (state_reg)
        H_BOOT: begin
          state_reg <= H_CAL;
        end
        H_CAL: begin
          wr_reg <= 1'b1;
          wdata_reg <= {`MODE_SELF, pend_reg[`MODE_LSB-1:0]};
          state_reg <= H_WAIT;
        end
        H_WAIT: begin
          if (!wr_reg && !link.busy) begin
            state_reg <= H_USER;
          end
        end
        H_USER: begin
          wr_reg <= 1'b1;
          wdata_reg <= pend_reg;
          last_reg <= pend_reg;
          state_reg <= H_IDLE;
        end
        H_IDLE: begin
          if (cmd_valid) begin
            pend_reg <= cmd_data;
            state_reg <= needs_cal(cmd_data, last_reg) ? H_CAL : H_USER;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // Results: unsettled words are dropped, settled ones pass on
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valid_reg <= 1'b0;
      data_reg <= '0;
      chan_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (link.res_valid && link.res_ready && link.res.settled) begin
        valid_reg <= 1'b1;
        data_reg <= link.res.data;
        chan_reg <= link.res.chan;
      end
    end
  end

  // Link drive and user-side outputs
  assign link.ctrl_wr = wr_reg;
  assign link.ctrl_wdata = wdata_reg;
  assign link.res_ready = out_ready;
  assign out_valid = valid_reg;
  assign out_data = data_reg;
  assign out_chan = chan_reg;
  assign cal_busy = link.busy || (state_reg != H_IDLE);
endmodule // sdadc_host

/* sdadc_link_asserts.sv */
// Checker of the link between the converter end and the controller end.
// Assumes one clock clk_sys and a synchronous active-high rst; instantiated beside the link.
`timescale 1ns/1ps
`include "sdadc_regs.svh"
module sdadc_link_asserts #(
  parameter int MOD_DIV = `CLK_HZ / `MOD_RATE_HZ
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire sdadc_pkg::ctrl_t ctrl_wdata,
  input wire sdadc_pkg::ctrl_t ctrl_rdata,
  input wire logic busy,
  input wire logic settled,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire sdadc_pkg::result_t res
);
  import sdadc_pkg::*;
  // Shortest settle: four conversions at the smallest notch count, less one tick of phase
  localparam int SETTLE_MIN = (int'(`SETTLE_PERIODS) * int'(`FS_MIN) - 1) * MOD_DIV;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since the last control write, saturating
  logic [19:0] since_wr_reg;
  always_ff @(posedge clk_sys) begin
    if (rst || ctrl_wr) begin
      since_wr_reg <= 20'h00000;
    end else if (since_wr_reg != 20'hFFFFF) begin
      since_wr_reg <= since_wr_reg + 20'h00001;
    end
  end
  // A write that starts a one-shot calibration
  sequence s_cal_req;
    ctrl_wr && (ctrl_wdata[`MODE_MSB:`MODE_LSB] inside {`MODE_SELF, `MODE_SYS_ZERO, `MODE_SYS_FULL, `MODE_SYS_OFFSET});
  endsequence
  sequence s_cal_end;
    $fell(busy);
  endsequence
  a_reset_word: assert property ($fell(rst) |-> ctrl_rdata == `CTRL_RST)
    else $error("control word not at its reset value");
  a_write_loads_word: assert property (ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata))
    else $error("written control word not held");
  a_cal_sets_busy: assert property (s_cal_req |=> busy)
    else $error("calibration write did not raise busy");
  a_normal_no_busy: assert property (ctrl_wr && ctrl_wdata[`MODE_MSB:`MODE_LSB] == `MODE_NORMAL |=> !busy)
    else $error("normal mode write raised busy");
  a_cal_mode_return: assert property (s_cal_end |-> ##[0:1] ctrl_rdata[`MODE_MSB:`MODE_LSB] == `MODE_NORMAL)
    else $error("mode field not back to normal after calibration");
  a_settle_restart: assert property (ctrl_wr && ctrl_wdata[`MODE_MSB:`MODE_LSB] != `MODE_BACKGROUND |=> !settled)
    else $error("settled not cleared by a write");
  a_settle_span: assert property (settled && ctrl_rdata[`MODE_MSB:`MODE_LSB] == `MODE_NORMAL |-> since_wr_reg >= SETTLE_MIN)
    else $error("settled before four conversions");
  a_result_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
    else $error("buffered result dropped or changed while stalled");
  a_bg_settled: assert property (res_valid && ctrl_rdata[`MODE_MSB:`MODE_LSB] == `MODE_BACKGROUND |-> res.settled)
    else $error("background result not marked settled");
endmodule // sdadc_link_asserts

/* sigma_delta_filter_calibration_control_test.sv */
// Testbench of both converter control ends joined by the link; the controller's user side is driven here.
// Assumes MOD_DIV of 4 and an analog front end modelled from ain_sel.
`timescale 1ns/1ps
`include "sdadc_regs.svh"
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module sigma_delta_filter_calibration_control_test;
  import sdadc_pkg::*;
  localparam int MOD_DIV = 4;
  localparam logic [11:0] FS_W = 12'h005; // Below the minimum, so the count clamps to 19
  localparam int CONV = int'(`FS_MIN) * MOD_DIV;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mod_bit = 1'b0;
  logic in_level = 1'b1;
  logic cmd_valid = 1'b0;
  logic out_ready = 1'b1;
  ctrl_t cmd_data = '0;
  ain_t ain_sel;
  logic chan_sel, out_valid, out_chan, cal_busy, cmd_ready;
  logic [23:0] zero_coef, span_coef, out_data;
  int error_cnt = 0;
  int checked = 0;
  adc_link link ();
  sdadc_device #(.MOD_DIV(MOD_DIV)) sdadc_device_i (.clk_sys(clk_sys), .rst(rst), .link(link), .mod_bit(mod_bit),
    .ain_sel(ain_sel), .chan_sel(chan_sel), .zero_coef(zero_coef), .span_coef(span_coef));
  sdadc_host sdadc_host_i (.clk_sys(clk_sys), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_chan(out_chan),
    .cal_busy(cal_busy));
  sdadc_link_asserts #(.MOD_DIV(MOD_DIV)) sdadc_link_asserts_i (.clk_sys(clk_sys), .rst(rst),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .busy(link.busy),
    .settled(link.settled), .res_valid(link.res_valid), .res_ready(link.res_ready), .res(link.res));
  // Clock of 10 ns
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Analog front end: shorted inputs give zeros, the reference all ones
  always @(negedge clk_sys) begin
    mod_bit <= (ain_sel == AIN_REF) ? 1'b1 : (ain_sel == AIN_SHORT) ? 1'b0 : in_level;
  end
  function automatic ctrl_t word(input mode_t m, input logic ch);
    return {m, ch, 8'h00, FS_W};
  endfunction
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Waits until the controller is idle and no calibration runs
  task automatic wait_idle();
    int n = 0;
    repeat (3) @(negedge clk_sys);
    while (!(cmd_ready === 1'b1 && cal_busy === 1'b0)) begin
      @(negedge clk_sys);
      n++;
      if (n > 40000) begin
        error_cnt++;
        finish_test();
      end
    end
  endtask
  task automatic send_cmd(input ctrl_t w);
    wait_idle();
    cmd_data = w;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    wait_idle();
  endtask
  // Takes the next one-cycle result pulse
  task automatic get_result(output logic [23:0] d, output logic c);
    int n = 0;
    @(negedge clk_sys);
    while (out_valid !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 4000) begin
        error_cnt++;
        finish_test();
      end
    end
    d = out_data;
    c = out_chan;
  endtask
  // Main sequence
  initial begin
    logic [23:0] d;
    logic c;
    time t0;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    wait_idle();
    `CHECK(link.ctrl_rdata, `CTRL_RST)
    `CHECK(zero_coef, 24'h000000)
    `CHECK(span_coef, 24'h000186)
    // New notch: controller calibrates first, then converts at the output rate
    send_cmd(word(`MODE_NORMAL, 1'b0));
    `CHECK(link.ctrl_rdata, word(`MODE_NORMAL, 1'b0))
    `CHECK(span_coef, 24'h000013)
    get_result(d, c);
    `CHECK(d, 24'h000013)
    t0 = $time;
    get_result(d, c);
    `CHECK(($time - t0) / 10, CONV)
    // Two-step system calibration
    send_cmd(word(`MODE_SYS_ZERO, 1'b0));
    `CHECK(zero_coef, 24'h000013)
    send_cmd(word(`MODE_SYS_FULL, 1'b0));
    `CHECK(span_coef, 24'h000000)
    // Background calibration: shorted zero and reference span, one result in six
    send_cmd(word(`MODE_BACKGROUND, 1'b0));
    get_result(d, c);
    get_result(d, c);
    t0 = $time;
    get_result(d, c);
    `CHECK(d, 24'h000013)
    `CHECK(($time - t0) / 10, 6 * CONV)
    `CHECK(zero_coef, 24'h000000)
    `CHECK(span_coef, 24'h000013)
    // Offset calibration: input zero, then reference span; mode returns to normal
    send_cmd(word(`MODE_SYS_OFFSET, 1'b0));
    `CHECK(zero_coef, 24'h000013)
    `CHECK(span_coef, 24'h000000)
    `CHECK(ain_sel, AIN_INPUT)
    `CHECK(link.ctrl_rdata[`MODE_MSB:`MODE_LSB], `MODE_NORMAL)
    // Receiver stalls: two results stay buffered, later ones are lost
    out_ready = 1'b0;
    repeat (5 * CONV) @(negedge clk_sys);
    `CHECK(link.overrun, 1'b1)
    `CHECK(link.res_valid, 1'b1)
    out_ready = 1'b1;
    get_result(d, c);
    `CHECK(d, 24'h000000)
    // Channel switch: recalibration, then settled data of the new channel
    send_cmd(word(`MODE_NORMAL, 1'b1));
    `CHECK(link.overrun, 1'b0)
    `CHECK(chan_sel, 1'b1)
    `CHECK(span_coef, 24'h000013)
    `CHECK(ain_sel, AIN_INPUT)
    get_result(d, c);
    `CHECK(c, 1'b1)
    `CHECK(d, 24'h000013)
    finish_test();
  end
endmodule // sigma_delta_filter_calibration_control_test
